// file: logic/ssc_pkg.sv
// Shared constants for the synchronous serial control block
package ssc_pkg;

  // ***************************************************************
  // Register byte offsets
  // ***************************************************************
  localparam logic [7:0] OFS_IFACE_ENABLE_CONTROL = 8'h00;
  localparam logic [7:0] OFS_SERIAL_TRANSFER_CTRL = 8'h04;
  localparam logic [7:0] OFS_DATA_BUFFER          = 8'h08;
  localparam logic [7:0] OFS_MODE_CTRL_STATUS     = 8'h0C;
  localparam logic [7:0] OFS_IDLE_AND_RATE        = 8'h10;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int BIT_IFACE_ENABLE   = 7;
  localparam int BIT_TRANSFER_RUN   = 7;
  localparam int BIT_TRANSFER_ABORT = 6;
  localparam int POS_TRANSFER_SEL   = 4;
  localparam int BIT_CR1_FIXED_ONE  = 3;
  localparam int POS_SCLK_SEL       = 0;
  localparam int POS_MODE_SEL       = 2;
  localparam int BIT_XFER_ACTIVE    = 3;
  localparam int BIT_SHIFT_ACTIVE   = 2;
  localparam int BIT_IDLE_RUN       = 6;

  // ***************************************************************
  // Reset values and encodings
  // ***************************************************************
  localparam logic [2:0] SCLK_SEL_RESET = 3'h1;
  localparam logic [2:0] SCLK_EXTERNAL  = 3'h7;
  localparam logic [1:0] XSEL_TX        = 2'h0;
  localparam logic [1:0] XSEL_TRX       = 2'h2;
  localparam logic [1:0] XSEL_RX        = 2'h3;
  localparam logic [1:0] MODE_PORT      = 2'h0;
  localparam logic [1:0] MODE_SIO       = 2'h1;
  localparam logic [1:0] MODE_TWO_WIRE  = 2'h2;
  localparam int         SCLK_EXP_BASE  = 3;
  localparam logic [7:0] SR_ONES_MASK   = 8'hF3;
  localparam logic [7:0] BR0_READ_FIXED = 8'hBE;

  // ***************************************************************
  // Engine states
  // ***************************************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_LOAD  = 3'b010,
    ST_SHIFT = 3'b100
  } ssc_state_type;

endpackage

// file: logic/ssc_clk_div.sv
// Serial clock divider producing half-period ticks
`timescale 1ns/1ps
module ssc_clk_div
  import ssc_pkg::*;
#(
  parameter int CNT_W = 10
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       run,
  input  wire logic [2:0] sclk_select,
  // Half-period tick
  output logic            tick
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] limit;

  // Half period is 2^n system clocks, n = code + 3
  always_comb begin
    limit    = CNT_W'((1 << (int'(sclk_select) + SCLK_EXP_BASE)) - 1);
    tick     = run && (cnt == limit);
    next_cnt = (!run || tick) ? '0 : CNT_W'(cnt + 1'b1);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    tick && sclk_select == 3'h0 |=> !tick [*7]) else $error("sclk tick spacing wrong");

endmodule

// file: logic/ssc_shifter.sv
// LSB-first shift register with bit counter
`timescale 1ns/1ps
module ssc_shifter #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Control
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_data,
  input  wire logic             fall,
  input  wire logic             rise,
  // Serial lines
  input  wire logic             serial_in,
  output logic                  serial_out,
  // Status
  output logic [WIDTH-1:0]      word,
  output logic                  last_bit
);

  localparam int CW = $clog2(WIDTH);

  logic [CW-1:0]    cnt;
  logic [CW-1:0]    next_cnt;
  logic [WIDTH-1:0] next_word;
  logic             next_serial_out;

  always_comb begin
    last_bit        = (cnt == CW'(WIDTH - 1));
    next_cnt        = cnt;
    next_word       = word;
    next_serial_out = serial_out;
    if (load) begin
      next_word = load_data;
      next_cnt  = '0;
    end else begin
      // Output on falling edge, sample on rising edge
      if (fall) begin
        next_serial_out = word[0];
      end
      if (rise) begin
        next_word = {serial_in, word[WIDTH-1:1]};
        next_cnt  = last_bit ? '0 : CW'(cnt + 1'b1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt        <= '0;
      word       <= '0;
      serial_out <= 1'b1;
    end else begin
      cnt        <= next_cnt;
      word       <= next_word;
      serial_out <= next_serial_out;
    end
  end

endmodule

// file: logic/ssc_top.sv
// Synchronous serial control block with APB register slave
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
module ssc_top
  import ssc_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int WORD_W = 8
) (
  // APB
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // System
  input  wire logic              idle_mode,
  output logic                   iface_irq,
  // Serial pins
  output logic                   serial_out_pin,
  input  wire logic              serial_in_pin,
  input  wire logic              serial_clock_pin_in,
  output logic                   serial_clock_pin_out,
  output logic                   serial_clock_pin_oe_n
);

  // ***************************************************************
  // State
  // ***************************************************************
  ssc_state_type     state;
  ssc_state_type     next_state;
  logic              iface_enable,    next_iface_enable;
  logic              transfer_run,    next_transfer_run;
  logic              transfer_abort,  next_transfer_abort;
  logic [1:0]        transfer_select, next_transfer_select;
  logic [2:0]        sclk_select,     next_sclk_select;
  logic              sclk_written,    next_sclk_written;
  logic [1:0]        iface_mode_select, next_iface_mode_select;
  logic              idle_run,        next_idle_run;
  logic [WORD_W-1:0] tx_data,         next_tx_data;
  logic [WORD_W-1:0] rx_data,         next_rx_data;
  logic              tx_full,         next_tx_full;
  logic              rx_full,         next_rx_full;
  logic              rx_pending,      next_rx_pending;
  logic              sclk_int,        next_sclk_int;
  logic              sclk_prev,       next_sclk_prev;
  logic              next_iface_irq;
  logic [31:0]       next_prdata;

  logic              setup_ph;
  logic              wr_acc;
  logic              rd_acc;
  logic              mapped;
  logic              sio_mode;
  logic              run_en;
  logic              is_ext;
  logic              sclk_lvl;
  logic              fall;
  logic              rise;
  logic              tick;
  logic              sh_load;
  logic [WORD_W-1:0] sh_word;
  logic              sh_last;
  logic              uses_tx;
  logic              uses_rx;
  logic              ready_go;

  // ***************************************************************
  // Submodules
  // ***************************************************************
  ssc_clk_div u_div (
    .pclk        (pclk),
    .presetn     (presetn),
    .run         (run_en && !is_ext && state == ST_SHIFT),
    .sclk_select (sclk_select),
    .tick        (tick)
  );

  ssc_shifter #(.WIDTH(WORD_W)) u_shift (
    .pclk       (pclk),
    .presetn    (presetn),
    .load       (sh_load),
    .load_data  (tx_data),
    .fall       (fall),
    .rise       (rise),
    .serial_in  (serial_in_pin),
    .serial_out (serial_out_pin),
    .word       (sh_word),
    .last_bit   (sh_last)
  );

  // ***************************************************************
  // Bus decode and serial clock
  // ***************************************************************
  always_comb begin
    setup_ph = psel && !penable;
    wr_acc   = psel && penable && pwrite;
    rd_acc   = psel && penable && !pwrite;
    mapped   = (paddr == OFS_IFACE_ENABLE_CONTROL) || (paddr == OFS_SERIAL_TRANSFER_CTRL) ||
               (paddr == OFS_DATA_BUFFER) || (paddr == OFS_MODE_CTRL_STATUS) ||
               (paddr == OFS_IDLE_AND_RATE);
    pready   = 1'b1;
    pslverr  = psel && penable && !mapped;
    sio_mode = (iface_mode_select == MODE_SIO);
    run_en   = iface_enable && sio_mode && !(idle_mode && !idle_run);
    is_ext   = (sclk_select == SCLK_EXTERNAL);
    sclk_lvl = is_ext ? serial_clock_pin_in : sclk_int;
    fall     = run_en && (state == ST_SHIFT) && sclk_prev && !sclk_lvl;
    rise     = run_en && (state == ST_SHIFT) && !sclk_prev && sclk_lvl;
    uses_tx  = (transfer_select == XSEL_TX) || (transfer_select == XSEL_TRX);
    uses_rx  = (transfer_select == XSEL_RX) || (transfer_select == XSEL_TRX);
    ready_go = (!uses_tx || tx_full) && (!uses_rx || !rx_full);
    sh_load  = run_en && (state == ST_LOAD) && !rx_pending && transfer_run && !transfer_abort &&
               ready_go;
    serial_clock_pin_out  = sclk_int;
    serial_clock_pin_oe_n = is_ext || !iface_enable;
  end

  // ***************************************************************
  // Next-state logic
  // ***************************************************************
  always_comb begin
    next_state             = state;
    next_iface_enable      = iface_enable;
    next_transfer_run      = transfer_run;
    next_transfer_abort    = transfer_abort;
    next_transfer_select   = transfer_select;
    next_sclk_select       = sclk_select;
    next_sclk_written      = sclk_written;
    next_iface_mode_select = iface_mode_select;
    next_idle_run          = idle_run;
    next_tx_data           = tx_data;
    next_rx_data           = rx_data;
    next_tx_full           = tx_full;
    next_rx_full           = rx_full;
    next_rx_pending        = rx_pending;
    next_sclk_int          = sclk_int;
    next_sclk_prev         = sclk_lvl;
    next_iface_irq         = 1'b0;
    next_prdata            = prdata;

    // Read data captured in setup, presented in access
    if (setup_ph) begin
      next_prdata = '0;
      if (!pwrite) begin
        unique case (paddr)
          OFS_IFACE_ENABLE_CONTROL: next_prdata[BIT_IFACE_ENABLE] = iface_enable;
          OFS_SERIAL_TRANSFER_CTRL: begin
            next_prdata[BIT_TRANSFER_RUN]   = transfer_run;
            next_prdata[BIT_TRANSFER_ABORT] = transfer_abort;
            next_prdata[POS_TRANSFER_SEL+:2] = transfer_select;
            next_prdata[BIT_CR1_FIXED_ONE]  = 1'b1;
            next_prdata[POS_SCLK_SEL+:3]    = sclk_select;
          end
          OFS_DATA_BUFFER: next_prdata[WORD_W-1:0] = rx_data;
          OFS_MODE_CTRL_STATUS: begin
            next_prdata[7:0] = sio_mode ? SR_ONES_MASK : 8'h00;
            next_prdata[BIT_XFER_ACTIVE]  = (state != ST_IDLE);
            next_prdata[BIT_SHIFT_ACTIVE] = (state == ST_SHIFT);
          end
          OFS_IDLE_AND_RATE: begin
            next_prdata[7:0] = BR0_READ_FIXED;
            next_prdata[BIT_IDLE_RUN] = idle_run;
          end
          default: next_prdata = '0;
        endcase
      end
    end

    // Register writes; only control register 0 while disabled
    if (wr_acc && paddr == OFS_IFACE_ENABLE_CONTROL) begin
      next_iface_enable = pwdata[BIT_IFACE_ENABLE];
    end
    if (wr_acc && iface_enable) begin
      unique case (paddr)
        OFS_SERIAL_TRANSFER_CTRL: begin
          next_transfer_run    = pwdata[BIT_TRANSFER_RUN];
          next_transfer_abort  = pwdata[BIT_TRANSFER_ABORT];
          next_transfer_select = pwdata[POS_TRANSFER_SEL+:2];
          next_sclk_select     = pwdata[POS_SCLK_SEL+:3];
          next_sclk_written    = 1'b1;
        end
        OFS_DATA_BUFFER: begin
          next_tx_data = pwdata[WORD_W-1:0];
          next_tx_full = 1'b1;
        end
        OFS_MODE_CTRL_STATUS: begin
          next_iface_mode_select = pwdata[POS_MODE_SEL+:2];
          if (pwdata[POS_MODE_SEL+:2] == MODE_SIO && !sclk_written) begin
            next_sclk_select[0] = 1'b0;
          end
        end
        OFS_IDLE_AND_RATE: next_idle_run = pwdata[BIT_IDLE_RUN];
        default: next_idle_run = idle_run;
      endcase
    end
    if (rd_acc && iface_enable && paddr == OFS_DATA_BUFFER) begin
      next_rx_full = 1'b0;
    end

    // Transfer engine
    if (run_en) begin
      if (tick) begin
        next_sclk_int = !sclk_int;
      end
      unique case (state)
        ST_IDLE: begin
          next_sclk_int = 1'b1;
          if (transfer_run && !transfer_abort) begin
            next_state = ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (transfer_abort) begin
            next_state      = ST_IDLE;
            next_rx_pending = 1'b0;
          end else if (rx_pending) begin
            next_rx_data    = sh_word;
            next_rx_full    = 1'b1;
            next_rx_pending = 1'b0;
            next_iface_irq  = 1'b1;
          end else if (!transfer_run) begin
            next_state = ST_IDLE;
          end else if (ready_go) begin
            next_state = ST_SHIFT;
            if (uses_tx) begin
              // A buffer write in this same cycle keeps the buffer full
              next_tx_full   = wr_acc && iface_enable && (paddr == OFS_DATA_BUFFER);
              next_iface_irq = 1'b1;
            end
          end
        end
        ST_SHIFT: begin
          if (transfer_abort) begin
            next_state    = ST_IDLE;
            next_sclk_int = 1'b1;
          end else if (rise && sh_last) begin
            next_state      = ST_LOAD;
            next_rx_pending = uses_rx;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state             <= ST_IDLE;
      iface_enable      <= 1'b0;
      transfer_run      <= 1'b0;
      transfer_abort    <= 1'b0;
      transfer_select   <= XSEL_TX;
      sclk_select       <= SCLK_SEL_RESET;
      sclk_written      <= 1'b0;
      iface_mode_select <= MODE_PORT;
      idle_run          <= 1'b0;
      tx_data           <= '0;
      rx_data           <= '0;
      tx_full           <= 1'b0;
      rx_full           <= 1'b0;
      rx_pending        <= 1'b0;
      sclk_int          <= 1'b1;
      sclk_prev         <= 1'b1;
      iface_irq         <= 1'b0;
      prdata            <= '0;
    end else begin
      state             <= next_state;
      iface_enable      <= next_iface_enable;
      transfer_run      <= next_transfer_run;
      transfer_abort    <= next_transfer_abort;
      transfer_select   <= next_transfer_select;
      sclk_select       <= next_sclk_select;
      sclk_written      <= next_sclk_written;
      iface_mode_select <= next_iface_mode_select;
      idle_run          <= next_idle_run;
      tx_data           <= next_tx_data;
      rx_data           <= next_rx_data;
      tx_full           <= next_tx_full;
      rx_full           <= next_rx_full;
      rx_pending        <= next_rx_pending;
      sclk_int          <= next_sclk_int;
      sclk_prev         <= next_sclk_prev;
      iface_irq         <= next_iface_irq;
      prdata            <= next_prdata;
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_disabled_frozen: assert property (!iface_enable |=> $stable(state))
    else $error("engine moved while disabled");
  a_regs_kept: assert property (!iface_enable && !(wr_acc && paddr == OFS_IFACE_ENABLE_CONTROL)
    |=> $stable(transfer_select) && $stable(sclk_select) && $stable(tx_data))
    else $error("register changed while disabled");
  a_run_start: assert property (run_en && state == ST_IDLE && transfer_run && !transfer_abort
    |=> state == ST_LOAD)
    else $error("transfer did not start");
  a_abort_stop: assert property (run_en && transfer_abort && state != ST_IDLE
    |=> state == ST_IDLE)
    else $error("abort did not end transfer");
  a_status_read: assert property (setup_ph && !pwrite && paddr == OFS_MODE_CTRL_STATUS
    |=> prdata[BIT_XFER_ACTIVE] == ($past(state) != ST_IDLE)
     && prdata[BIT_SHIFT_ACTIVE] == ($past(state) == ST_SHIFT))
    else $error("status bits wrong");
  a_unused_ones: assert property (setup_ph && !pwrite && paddr == OFS_MODE_CTRL_STATUS && sio_mode
    |=> (prdata[7:0] & SR_ONES_MASK) == SR_ONES_MASK)
    else $error("unused status bits not one");
  a_irq_on_load: assert property (sh_load && uses_tx
    |=> iface_irq && state == ST_SHIFT && tx_full == $past(wr_acc && paddr == OFS_DATA_BUFFER))
    else $error("tx load did not raise irq");
  a_word_end: assert property (run_en && state == ST_SHIFT && rise && sh_last && !transfer_abort
    |=> state == ST_LOAD && rx_pending == $past(uses_rx))
    else $error("word end mishandled");
  a_idle_stop: assert property (idle_mode && !idle_run |=> $stable(state) && $stable(sclk_int))
    else $error("ran in idle with idle_run low");

endmodule

// file: verification/ssc_peer.sv
// Clocked serial peripheral model on the far side of the pins
`timescale 1ns/1ps
module ssc_peer (
  // Reset
  input  wire logic       rst_n,
  // Serial pins
  input  wire logic       sclk,
  input  wire logic       sdo,
  output logic            sdi,
  // Bench side
  input  wire logic [7:0] tx_byte,
  output logic [7:0]      rx_byte,
  output int              n_bits
);
  // Capture on rising clock, LSB arrives first
  always @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_byte <= 8'h00;
      n_bits  <= 0;
    end else begin
      rx_byte <= {sdo, rx_byte[7:1]};
      n_bits  <= n_bits + 1;
    end
  end
  // Present next bit on falling clock
  always @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      sdi <= 1'b1;
    end else begin
      sdi <= tx_byte[n_bits[2:0]];
    end
  end
endmodule

// file: verification/sync_serial_sio_control_bench.sv
// Self-checking bench for the serial control block
`timescale 1ns/1ps
module sync_serial_sio_control_bench;
  import ssc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, idle_mode, irq_seen;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        pready, pslverr, iface_irq, sdo, sdi, sclk, oe_n, err, ext_clk;
  wire logic   sck;
  logic [7:0]  rx_byte;
  int          n_bits, n_mismatch, samples_checked, n;

  ssc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .idle_mode(idle_mode), .iface_irq(iface_irq), .serial_out_pin(sdo), .serial_in_pin(sdi),
    .serial_clock_pin_in(sck), .serial_clock_pin_out(sclk), .serial_clock_pin_oe_n(oe_n));
  ssc_peer peer (.rst_n(presetn), .sclk(sck), .sdo(sdo), .sdi(sdi), .tx_byte(8'h3C), .rx_byte(rx_byte),
    .n_bits(n_bits));
  // Clock pin: driven by the block, or by the far side when released
  assign sck = oe_n ? ext_clk : sclk;

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (!presetn) begin
      irq_seen <= 1'b0;
    end else if (iface_irq === 1'b1) begin
      irq_seen <= 1'b1;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, exp);
  endtask

  task automatic t_reset;
    rd_chk(OFS_IFACE_ENABLE_CONTROL, 32'h0000_0000);
    rd_chk(OFS_SERIAL_TRANSFER_CTRL, 32'h0000_0009);
    rd_chk(OFS_IDLE_AND_RATE, 32'h0000_00BE);
    rd_chk(8'h20, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
  endtask

  task automatic t_regs;
    apb(1'b1, OFS_IFACE_ENABLE_CONTROL, 32'h0000_0080);
    rd_chk(OFS_IFACE_ENABLE_CONTROL, 32'h0000_0080);
    apb(1'b1, OFS_MODE_CTRL_STATUS, 32'h0000_0000);
    rd_chk(OFS_MODE_CTRL_STATUS, 32'h0000_0000);
    apb(1'b1, OFS_MODE_CTRL_STATUS, 32'h0000_0004);
    rd_chk(OFS_MODE_CTRL_STATUS, 32'h0000_00F3);
    rd_chk(OFS_SERIAL_TRANSFER_CTRL, 32'h0000_0008);
    apb(1'b1, OFS_SERIAL_TRANSFER_CTRL, 32'hFFFF_FF77);
    rd_chk(OFS_SERIAL_TRANSFER_CTRL, 32'h0000_007F);
    apb(1'b1, OFS_SERIAL_TRANSFER_CTRL, 32'h0000_0060);
    apb(1'b1, OFS_IDLE_AND_RATE, 32'h0000_00FF);
    rd_chk(OFS_IDLE_AND_RATE, 32'h0000_00FE);
    apb(1'b1, OFS_IFACE_ENABLE_CONTROL, 32'h0000_0000);
    apb(1'b1, OFS_SERIAL_TRANSFER_CTRL, 32'h0000_0040);
    rd_chk(OFS_SERIAL_TRANSFER_CTRL, 32'h0000_0068);
    apb(1'b1, OFS_IFACE_ENABLE_CONTROL, 32'h0000_0080);
    rd_chk(OFS_IDLE_AND_RATE, 32'h0000_00FE);
  endtask

  task automatic t_xfer;
    idle_mode <= 1'b1;
    apb(1'b1, OFS_DATA_BUFFER, 32'h0000_00A5);
    rd_chk(OFS_DATA_BUFFER, 32'h0000_0000);
    apb(1'b1, OFS_SERIAL_TRANSFER_CTRL, 32'h0000_00A0);
    rd_chk(OFS_MODE_CTRL_STATUS, 32'h0000_00FB);
    chk({31'h0, oe_n}, 32'h0000_0000);
    n = 0;
    while (sclk !== 1'b0 && n < 200) begin
      @(negedge pclk);
      n++;
    end
    n = 0;
    while (sclk === 1'b0 && n < 200) begin
      @(negedge pclk);
      n++;
    end
    chk(n, 32'd8);
    n = 0;
    while (n_bits < 8 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk(n_bits, 32'h0000_0008);
    chk({24'h0, rx_byte}, 32'h0000_00A5);
    chk({31'h0, irq_seen}, 32'h0000_0001);
    repeat (20) @(posedge pclk);
    rd_chk(OFS_DATA_BUFFER, 32'h0000_003C);
    apb(1'b1, OFS_SERIAL_TRANSFER_CTRL, 32'h0000_0060);
    rd_chk(OFS_MODE_CTRL_STATUS, 32'h0000_00F3);
    chk({31'h0, sclk}, 32'h0000_0001);
  endtask

  task automatic t_ext;
    apb(1'b1, OFS_SERIAL_TRANSFER_CTRL, 32'h0000_0047);
    apb(1'b1, OFS_DATA_BUFFER, 32'h0000_005A);
    apb(1'b1, OFS_SERIAL_TRANSFER_CTRL, 32'h0000_0087);
    chk({31'h0, oe_n}, 32'h0000_0001);
    repeat (4) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      ext_clk <= 1'b0;
      repeat (4) @(posedge pclk);
      ext_clk <= 1'b1;
      repeat (4) @(posedge pclk);
    end
    chk({24'h0, rx_byte}, 32'h0000_005A);
    apb(1'b1, OFS_SERIAL_TRANSFER_CTRL, 32'h0000_0007);
    rd_chk(OFS_MODE_CTRL_STATUS, 32'h0000_00F3);
  endtask

  task automatic t_idle;
    apb(1'b1, OFS_IDLE_AND_RATE, 32'h0000_0000);
    apb(1'b1, OFS_SERIAL_TRANSFER_CTRL, 32'h0000_0040);
    apb(1'b1, OFS_DATA_BUFFER, 32'h0000_0011);
    apb(1'b1, OFS_SERIAL_TRANSFER_CTRL, 32'h0000_0080);
    rd_chk(OFS_MODE_CTRL_STATUS, 32'h0000_00F3);
    apb(1'b1, OFS_IDLE_AND_RATE, 32'h0000_0040);
    rd_chk(OFS_MODE_CTRL_STATUS, 32'h0000_00FB);
    rd_chk(OFS_MODE_CTRL_STATUS, 32'h0000_00FF);
    apb(1'b1, OFS_SERIAL_TRANSFER_CTRL, 32'h0000_0040);
    rd_chk(OFS_MODE_CTRL_STATUS, 32'h0000_00F3);
    chk({31'h0, sclk}, 32'h0000_0001);
  endtask

  task automatic finish_test;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, idle_mode, ext_clk} = 5'h01;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_xfer();
    t_ext();
    t_idle();
    finish_test();
  end

  initial begin
    #40000;
    n_mismatch++;
    finish_test();
  end
endmodule
